// [slot_power_breaker_fault_logic_test.sv]
// Bench for the dual-slot breaker fault logic
`timescale 1ns/100ps
`default_nettype none
module slot_power_breaker_fault_logic_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] slot_main_on;
  logic [1:0] aux_enable;
  logic [1:0] card_latch_n;
  spbf_pkg::spbf_sense_t sense_a = '0;
  spbf_pkg::spbf_sense_t sense_b = '0;
  spbf_pkg::spbf_slot_out_t slot_a;
  spbf_pkg::spbf_slot_out_t slot_b;
  logic alert_out_n;
  int err_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  spbf_host i_spbf_host (.clk(clk), .slot_main_on(slot_main_on), .aux_enable(aux_enable), .card_latch_n(card_latch_n));
  spbf_top #(.FAULT_DELAY_CYC(20)) i_spbf_top (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .slot_main_on(slot_main_on),
    .aux_enable(aux_enable), .card_latch_n(card_latch_n), .sense_a(sense_a), .sense_b(sense_b), .slot_a(slot_a),
    .slot_b(slot_b), .alert_out_n(alert_out_n));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  // Rail flags of a slot with the shared alert last, or with the regulating flag last in one check
  task automatic ck(input logic [6:0] v, input logic [6:0] e);
    n_checks++;
    if (v !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, v, e);
    end
  endtask : ck
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic t_main;
    i_spbf_host.drive(2'h1, 2'h1, 2'h3, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h1D);
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h3D);
    i_spbf_host.drive(2'h1, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h6D);
    ck({slot_b[6:1], alert_out_n}, 7'h1D);
    sense_a.high_over_limit = 1'b1;
    w(12);
    ck({slot_a[6:1], slot_a.regulating}, 7'h6D);
    w(20);
    ck({slot_a[6:1], alert_out_n}, 7'h34);
    ck({slot_b[6:1], alert_out_n}, 7'h1C);
    sense_a.high_over_limit = 1'b0;
    w(10);
    ck({slot_a[6:1], alert_out_n}, 7'h34);
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h35);
    i_spbf_host.drive(2'h1, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h6D);
    $display("main trip test done");
  endtask : t_main
  task automatic t_fast;
    sense_a.high_fast = 1'b1;
    w(6);
    ck({slot_a[6:1], alert_out_n}, 7'h34);
    sense_a.high_fast = 1'b0;
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    i_spbf_host.drive(2'h1, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h6D);
    $display("fast trip test done");
  endtask : t_fast
  task automatic t_uv;
    sense_a.main_low_uv = 1'b1;
    w(6);
    ck({slot_a[6:1], alert_out_n}, 7'h36);
    sense_a.main_low_uv = 1'b0;
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h35);
    i_spbf_host.drive(2'h1, 2'h1, 2'h2, 8);
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h3D);
    sense_a.main_high_uv = 1'b1;
    w(8);
    ck({slot_a[6:1], alert_out_n}, 7'h3F);
    sense_a.main_high_uv = 1'b0;
    $display("undervoltage test done");
  endtask : t_uv
  task automatic t_aux;
    sense_a.aux_over_limit = 1'b1;
    w(12);
    ck({slot_a[6:1], alert_out_n}, 7'h3D);
    w(20);
    ck({slot_a[6:1], alert_out_n}, 7'h18);
    sense_a.aux_over_limit = 1'b0;
    i_spbf_host.drive(2'h0, 2'h0, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h19);
    i_spbf_host.drive(2'h0, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h3D);
    $display("aux trip test done");
  endtask : t_aux
  task automatic t_hold;
    clk_en = 1'b0;
    i_spbf_host.drive(2'h1, 2'h1, 2'h2, 8);
    ck({slot_a[6:1], alert_out_n}, 7'h3D);
    clk_en = 1'b1;
    w(6);
    ck({slot_a[6:1], alert_out_n}, 7'h6D);
    $display("clock enable test done");
  endtask : t_hold
  initial
  begin
    w(8);
    ck({slot_a[6:1], alert_out_n}, 7'h1D);
    w(8);
    rst_n = 1'b1;
    t_main();
    t_fast();
    t_uv();
    t_aux();
    t_hold();
    conclude();
  end
  initial
  begin
    #20000;
    err_count++;
    conclude();
  end
endmodule : slot_power_breaker_fault_logic_test
bind spbf_top spbf_chk i_spbf_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .slot_main_on(slot_main_on),
  .aux_enable(aux_enable), .card_latch_n(card_latch_n), .sense_a(sense_a), .sense_b(sense_b), .slot_a(slot_a),
  .slot_b(slot_b), .alert_out_n(alert_out_n));
`default_nettype wire

// [spbf_chk.sv]
// Assertion checker for the dual-slot breaker fault logic
`timescale 1ns/100ps
`default_nettype none
module spbf_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host levels
  input wire logic [1:0] slot_main_on,
  input wire logic [1:0] aux_enable,
  input wire logic [1:0] card_latch_n,
  // Sensors and results
  input wire spbf_pkg::spbf_sense_t sense_a,
  input wire spbf_pkg::spbf_sense_t sense_b,
  input wire spbf_pkg::spbf_slot_out_t slot_a,
  input wire spbf_pkg::spbf_slot_out_t slot_b,
  input wire logic alert_out_n
);
  logic [3:0] prev;
  logic [3:0] age;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Cycles since any enable fell, saturating
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev <= 4'h0;
      age <= 4'hF;
    end
    else
    begin
      prev <= {slot_main_on, aux_enable};
      if (|(prev & ~{slot_main_on, aux_enable}))
        age <= 4'h0;
      else if (age != 4'hF)
        age <= age + 4'h1;
    end
  end
  property p_stby; (sense_a.main_high_uv || sense_a.main_low_uv) [*5] |-> slot_a.standby; endproperty
  a_stby: assert property (p_stby) else $error("no standby");
  property p_fast; sense_a.high_fast && slot_a.main_on |-> ##[1:5] !slot_a.main_on; endproperty
  a_fast: assert property (p_fast) else $error("fast trip late");
  property p_alert; $fell(slot_a.main_fault_n) || $fell(slot_a.aux_fault_n) |-> !alert_out_n; endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  property p_mdly; $rose(sense_a.high_over_limit) && slot_a.main_on |-> (slot_a.main_on && slot_a.main_fault_n) [*8];
  endproperty
  a_mdly: assert property (p_mdly) else $error("main trip early");
  property p_adly; $rose(sense_a.aux_over_limit) && slot_a.aux_on |-> slot_a.aux_fault_n [*8]; endproperty
  a_adly: assert property (p_adly) else $error("aux trip early");
  property p_excl; !slot_a.main_fault_n |-> !slot_a.main_on; endproperty
  a_excl: assert property (p_excl) else $error("faulted rail on");
  property p_rel; $rose(alert_out_n) |-> age < 4'h8; endproperty
  a_rel: assert property (p_rel) else $error("alert freed alone");
  property p_latch; $rose(slot_a.main_on) |-> !$past(card_latch_n[0], 3) && $past(slot_main_on[0], 3); endproperty
  a_latch: assert property (p_latch) else $error("main on unasked");
  property p_aux; $rose(slot_a.aux_on) |-> $past(aux_enable[0], 3); endproperty
  a_aux: assert property (p_aux) else $error("aux on unasked");
  c_trip: cover property ($fell(slot_a.main_fault_n));
  c_aux: cover property ($fell(slot_a.aux_fault_n));
  c_rel: cover property ($rose(alert_out_n));
endmodule : spbf_chk
`default_nettype wire

// [spbf_host.sv]
// Host model driving slot enables and card latches
`timescale 1ns/100ps
`default_nettype none
module spbf_host (
  // Clock
  input wire logic clk,
  // Host levels
  output logic [1:0] slot_main_on,
  output logic [1:0] aux_enable,
  output logic [1:0] card_latch_n
);
  initial
  begin
    slot_main_on = 2'h0;
    aux_enable = 2'h0;
    card_latch_n = 2'h3;
  end
  task automatic drive(input logic [1:0] m, input logic [1:0] a, input logic [1:0] l, input int n);
    @(posedge clk);
    #1;
    slot_main_on = m;
    aux_enable = a;
    card_latch_n = l;
    repeat (n) @(posedge clk);
    #1;
  endtask : drive
endmodule : spbf_host
`default_nettype wire

// [spbf_pkg.sv]
// Types shared by the slot power breaker fault logic
package spbf_pkg;
  typedef enum logic [1:0] {SPBF_OFF, SPBF_ON, SPBF_TRIPPED} spbf_main_state_t;
  typedef struct packed {
    logic main_high_uv;
    logic main_low_uv;
    logic high_over_limit;
    logic low_over_limit;
    logic high_fast;
    logic low_fast;
    logic aux_over_limit;
  } spbf_sense_t;
  typedef struct packed {
    logic main_on;
    logic aux_on;
    logic discharge;
    logic main_fault_n;
    logic aux_fault_n;
    logic standby;
    logic regulating;
  } spbf_slot_out_t;
endpackage : spbf_pkg

// [spbf_regs.svh]
// Timing and timer width constants for the slot power breaker fault logic
`ifndef SPBF_REGS_SVH
`define SPBF_REGS_SVH
`define SPBF_FAULT_DELAY_MS 40
`define SPBF_CLK_MHZ 100
`define SPBF_FAULT_DELAY_CYC (`SPBF_FAULT_DELAY_MS * 1000 * `SPBF_CLK_MHZ)
`define SPBF_TMR_W 23
`endif

// [spbf_slot.sv]
// One slot of breaker and enable logic
`timescale 1ns/100ps
`default_nettype none
`include "spbf_regs.svh"
module spbf_slot #(
  parameter int unsigned FAULT_DELAY_CYC = `SPBF_FAULT_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Synchronised host inputs and sensors
  input wire logic slot_main_on,
  input wire logic aux_enable,
  input wire logic card_latch_n,
  input wire spbf_pkg::spbf_sense_t sense,
  // Slot results
  output spbf_pkg::spbf_slot_out_t slot_out,
  output logic main_trip,
  output logic aux_trip,
  output logic release_pulse
);
  logic main_on_q;
  logic aux_on_q;
  logic main_flt;
  logic aux_flt;
  logic main_armed;
  logic aux_armed;
  logic [`SPBF_TMR_W-1:0] main_tmr;
  logic [`SPBF_TMR_W-1:0] aux_tmr;
  spbf_pkg::spbf_main_state_t state;
  logic main_rise;
  logic main_fall;
  logic aux_rise;
  logic aux_fall;
  logic uv;
  logic main_ovl;
  logic main_fast;
  logic main_expired;
  logic aux_expired;

  localparam logic [`SPBF_TMR_W-1:0] TMR_LAST = `SPBF_TMR_W'(FAULT_DELAY_CYC - 1);

  assign main_rise = slot_main_on & ~main_on_q;
  assign main_fall = ~slot_main_on & main_on_q;
  assign aux_rise = aux_enable & ~aux_on_q;
  assign aux_fall = ~aux_enable & aux_on_q;
  assign uv = sense.main_high_uv | sense.main_low_uv;
  assign main_ovl = sense.high_over_limit | sense.low_over_limit;
  assign main_fast = sense.high_fast | sense.low_fast;
  assign main_expired = main_tmr == TMR_LAST;
  assign aux_expired = aux_tmr == TMR_LAST;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_on_q <= 1'b0;
      aux_on_q <= 1'b0;
    end
    else if (clk_en)
    begin
      main_on_q <= slot_main_on;
      aux_on_q <= aux_enable;
    end
  end

  // Main rail state machine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= spbf_pkg::SPBF_OFF;
    else if (clk_en)
    begin
      unique case (state)
        spbf_pkg::SPBF_OFF:
          if (main_rise && !card_latch_n && !uv)
            state <= spbf_pkg::SPBF_ON;
        spbf_pkg::SPBF_ON:
          if (main_fast || (main_ovl && main_expired) || uv)
            state <= spbf_pkg::SPBF_TRIPPED;
          else if (!slot_main_on || card_latch_n)
            state <= spbf_pkg::SPBF_OFF;
        spbf_pkg::SPBF_TRIPPED:
          if (!slot_main_on)
            state <= spbf_pkg::SPBF_OFF;
        default:
          state <= spbf_pkg::SPBF_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      main_tmr <= '0;
    else if (clk_en)
    begin
      if (state == spbf_pkg::SPBF_ON && main_ovl && !main_expired)
        main_tmr <= main_tmr + 1'b1;
      else if (!(state == spbf_pkg::SPBF_ON && main_ovl))
        main_tmr <= '0;
    end
  end

  // Aux rail; independent of mains
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_armed <= 1'b0;
      aux_tmr <= '0;
    end
    else if (clk_en)
    begin
      // Level enable; a latched fault holds it off until re-armed
      if (aux_trip || !aux_enable || card_latch_n)
        aux_armed <= 1'b0;
      else if (!aux_flt)
        aux_armed <= 1'b1;
      if (aux_armed && sense.aux_over_limit && !aux_expired)
        aux_tmr <= aux_tmr + 1'b1;
      else if (!(aux_armed && sense.aux_over_limit))
        aux_tmr <= '0;
    end
  end

  assign main_trip = clk_en && state == spbf_pkg::SPBF_ON && (main_fast || (main_ovl && main_expired) || uv);
  assign aux_trip = clk_en && aux_armed && sense.aux_over_limit && aux_expired;
  assign release_pulse = clk_en && ((main_fall && main_flt) || (aux_fall && aux_flt));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_flt <= 1'b0;
      aux_flt <= 1'b0;
    end
    else if (clk_en)
    begin
      if (main_trip)
        main_flt <= 1'b1;
      else if (main_rise)
        main_flt <= 1'b0;
      if (aux_trip)
        aux_flt <= 1'b1;
      else if (aux_rise)
        aux_flt <= 1'b0;
    end
  end

  assign main_armed = state == spbf_pkg::SPBF_ON;
  always_comb
  begin
    slot_out.main_on = main_armed;
    slot_out.aux_on = aux_armed;
    slot_out.discharge = !main_armed;
    slot_out.main_fault_n = !main_flt;
    slot_out.aux_fault_n = !aux_flt;
    slot_out.standby = uv;
    slot_out.regulating = main_armed && main_ovl;
  end
endmodule : spbf_slot
`default_nettype wire

// [spbf_top.sv]
// Dual-slot power breaker fault logic top
`timescale 1ns/100ps
`default_nettype none
`include "spbf_regs.svh"
module spbf_top #(
  parameter int unsigned FAULT_DELAY_CYC = `SPBF_FAULT_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host enables per slot, index 0 is slot A
  input wire logic [1:0] slot_main_on,
  input wire logic [1:0] aux_enable,
  input wire logic [1:0] card_latch_n,
  // Analog comparator results per slot
  input wire spbf_pkg::spbf_sense_t sense_a,
  input wire spbf_pkg::spbf_sense_t sense_b,
  // Rail controls and status per slot
  output spbf_pkg::spbf_slot_out_t slot_a,
  output spbf_pkg::spbf_slot_out_t slot_b,
  // Shared alert
  output logic alert_out_n
);
  localparam int W = $bits(spbf_pkg::spbf_sense_t) + 3;
  spbf_pkg::spbf_slot_out_t raw [2];
  logic trip_seen;
  logic rel_seen;
  logic [1:0] main_trip;
  logic [1:0] aux_trip;
  logic [1:0] release_pulse;

  // Pins are asynchronous, so two stages each
  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_slot
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta <= {{(W-1){1'b0}}, 1'b1};
          sync <= {{(W-1){1'b0}}, 1'b1};
        end
        else if (clk_en)
        begin
          meta <= {(s == 0) ? sense_a : sense_b, slot_main_on[s], aux_enable[s], card_latch_n[s]};
          sync <= meta;
        end
      end
      spbf_slot #(.FAULT_DELAY_CYC(FAULT_DELAY_CYC)) u_slot (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .slot_main_on(sync[2]),
        .aux_enable(sync[1]),
        .card_latch_n(sync[0]),
        .sense(sync[W-1:3]),
        .slot_out(raw[s]),
        .main_trip(main_trip[s]),
        .aux_trip(aux_trip[s]),
        .release_pulse(release_pulse[s])
      );
    end
  endgenerate

  // Registered outputs; reset value has both rails off, discharge on and no faults
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_a <= 7'h1C;
      slot_b <= 7'h1C;
    end
    else if (clk_en)
    begin
      slot_a <= raw[0];
      slot_b <= raw[1];
    end
  end

  // Delay both events one cycle so alert lines up with the registered slot outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_seen <= 1'b0;
      rel_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      trip_seen <= |main_trip || |aux_trip;
      rel_seen <= |release_pulse;
    end
  end

  // trip asserts alert; set beats release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      alert_out_n <= 1'b1;
    else if (clk_en)
    begin
      if (trip_seen)
        alert_out_n <= 1'b0;
      else if (rel_seen)
        alert_out_n <= 1'b1;
    end
  end
endmodule : spbf_top
`default_nettype wire
